// file: hw/psc_defines.svh
// psc_defines.svh: constants for the pseudo-static RAM host controller
// assumes a 20 MHz clock and a 22-bit word address, 16-bit data bus
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

`define PSC_CLK_MHZ 20
`define PSC_ADDR_W 22
`define PSC_DATA_W 16
`define PSC_HIGHEST_ADDR 22'h3fffff
`define PSC_OTHER_ADDR 22'h000000
`define PSC_SLEEP_HOLD_US 50
`define PSC_IDLE_HOLD_US 200
`define PSC_WAKE_PART_NS 30
`define PSC_SLEEP_HOLD_CYC (`PSC_SLEEP_HOLD_US * `PSC_CLK_MHZ)
`define PSC_IDLE_HOLD_CYC (`PSC_IDLE_HOLD_US * `PSC_CLK_MHZ)
`define PSC_WAKE_PART_CYC ((`PSC_WAKE_PART_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_ACC_NS 100
`define PSC_ACC_CYC ((`PSC_ACC_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_GAP_NS 50
`define PSC_GAP_CYC ((`PSC_GAP_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_CNT_W 16
`define PSC_FIRST_WR_DATA 16'h0000
`define PSC_DENS_16M 16'h0004
`define PSC_DENS_8M 16'h0005
`define PSC_DENS_4M 16'h0006
`define PSC_DENS_0M 16'h0007

`endif

// file: hw/psc_host.sv
// psc_host: host controller for a pseudo-static RAM on an async SRAM-style bus
// assumes rst marks power application; pins are sampled synchronous to clk
`timescale 1ns/1ns
`default_nettype none
`include "psc_defines.svh"

module psc_host
  import psc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user request side
  input wire logic req_valid,
  input wire psc_req_s req,
  output logic req_ready,
  output logic [`PSC_DATA_W-1:0] rdata,
  output logic rdata_valid,
  // mode and power requests
  input wire logic prog_valid,
  input wire psc_dens_e prog_dens,
  input wire logic sleep_req,
  output logic init_done,
  output psc_dens_e dens_now,
  output logic dens_known,
  // memory pins
  output logic [`PSC_ADDR_W-1:0] mem_addr,
  output psc_ctl_s mem_ctl,
  input wire logic [`PSC_DATA_W-1:0] mem_dq_in,
  output logic [`PSC_DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe
);
  typedef enum logic [10:0] {
    ST_PWR_LOW = 11'h001,
    ST_PWR_IDLE = 11'h002,
    ST_READY = 11'h004,
    ST_SETUP = 11'h008,
    ST_STROBE = 11'h010,
    ST_GAP = 11'h020,
    ST_DUMMY = 11'h040,
    ST_SLEEP = 11'h080,
    ST_WAKE = 11'h100,
    ST_DONE = 11'h200,
    ST_PROG = 11'h400
  } psc_state_e;

  psc_state_e state;
  psc_op_e cur_op;
  logic [`PSC_ADDR_W-1:0] cur_addr;
  logic [`PSC_DATA_W-1:0] cur_data;
  logic [1:0] cur_be;
  logic [1:0] prog_step;
  logic prog_active;
  psc_dens_e prog_target;
  logic last_was_high;
  logic dummy_active;
  logic low_armed;
  logic [2:0] page_idx;
  logic tmr_load;
  logic [`PSC_CNT_W-1:0] tmr_count;
  logic tmr_done;

  function automatic logic [`PSC_DATA_W-1:0] dens_code(input psc_dens_e d);
    unique case (d)
      PSC_DENS_16: dens_code = `PSC_DENS_16M;
      PSC_DENS_8: dens_code = `PSC_DENS_8M;
      PSC_DENS_4: dens_code = `PSC_DENS_4M;
      PSC_DENS_NONE: dens_code = `PSC_DENS_0M;
    endcase
  endfunction : dens_code

  function automatic logic [`PSC_CNT_W-1:0] cyc(input int n);
    cyc = n[`PSC_CNT_W-1:0];
  endfunction : cyc

  psc_timer u_timer (
    .clk(clk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // timer loads on every state entry that needs an interval
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = cyc(`PSC_ACC_CYC);
    unique case (state)
      ST_PWR_LOW: begin
        if (!low_armed) begin
          tmr_load = 1'b1;
          tmr_count = cyc(`PSC_SLEEP_HOLD_CYC);
        end else if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = cyc(`PSC_IDLE_HOLD_CYC);
        end
      end
      ST_SETUP, ST_DUMMY: begin
        tmr_load = 1'b1;
        tmr_count = cyc(`PSC_ACC_CYC);
      end
      ST_STROBE: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = cyc(`PSC_GAP_CYC);
        end
      end
      ST_SLEEP: begin
        if (!sleep_req) begin
          tmr_load = 1'b1;
          tmr_count = (dens_known && dens_now != PSC_DENS_NONE) ?
            cyc(`PSC_WAKE_PART_CYC) : cyc(`PSC_IDLE_HOLD_CYC);
        end
      end
      default: begin
      end
    endcase
  end

  // main sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_PWR_LOW;
      cur_op <= PSC_OP_READ;
      cur_addr <= `PSC_OTHER_ADDR;
      cur_data <= `PSC_DATA_W'h0;
      cur_be <= 2'h0;
      prog_step <= 2'h0;
      prog_active <= 1'b0;
      prog_target <= PSC_DENS_16;
      page_idx <= 3'h0;
      dummy_active <= 1'b0;
    end else begin
      unique case (state)
        ST_PWR_LOW: begin
          if (low_armed && tmr_done) begin
            state <= ST_PWR_IDLE;
          end
        end
        ST_PWR_IDLE: begin
          if (tmr_done) begin
            state <= ST_READY;
          end
        end
        ST_READY: begin
          if (sleep_req) begin
            state <= ST_SLEEP;
          end else if (prog_valid) begin
            prog_target <= prog_dens;
            prog_step <= 2'h0;
            if (last_was_high) begin
              dummy_active <= 1'b1;
              cur_op <= PSC_OP_READ;
              cur_addr <= `PSC_OTHER_ADDR;
              cur_be <= 2'h3;
              state <= ST_DUMMY;
            end else begin
              prog_active <= 1'b1;
              state <= ST_PROG;
            end
          end else if (req_valid) begin
            cur_op <= req.op;
            cur_addr <= req.addr;
            cur_data <= req.wdata;
            cur_be <= (req.op == PSC_OP_PAGE) ? 2'h3 : req.byte_en;
            page_idx <= 3'h0;
            state <= ST_SETUP;
          end
        end
        ST_PROG: begin
          cur_addr <= `PSC_HIGHEST_ADDR;
          cur_be <= 2'h3;
          cur_op <= prog_step[1] ? PSC_OP_WRITE : PSC_OP_READ;
          cur_data <= (prog_step == 2'h3) ? dens_code(prog_target) : `PSC_FIRST_WR_DATA;
          state <= ST_SETUP;
        end
        ST_DUMMY: begin
          state <= ST_STROBE;
        end
        ST_SETUP: begin
          state <= ST_STROBE;
        end
        ST_STROBE: begin
          if (tmr_done) begin
            if (cur_op == PSC_OP_PAGE && page_idx != 3'h7) begin
              page_idx <= page_idx + 3'h1;
              state <= ST_SETUP;
            end else begin
              state <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (tmr_done) begin
            if (prog_active && prog_step != 2'h3) begin
              prog_step <= prog_step + 2'h1;
              state <= ST_PROG;
            end else if (dummy_active) begin
              dummy_active <= 1'b0;
              prog_active <= 1'b1;
              state <= ST_PROG;
            end else begin
              prog_active <= 1'b0;
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state <= ST_READY;
        end
        ST_SLEEP: begin
          if (!sleep_req) begin
            state <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (tmr_done) begin
            state <= ST_READY;
          end
        end
        default: begin
          state <= ST_READY;
        end
      endcase
    end
  end

  // first cycle out of reset loads the low-power hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_armed <= 1'b0;
    end else begin
      low_armed <= (state == ST_PWR_LOW);
    end
  end

  // density known after programming; unknown at power-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dens_now <= PSC_DENS_NONE;
      dens_known <= 1'b0;
    end else if (state == ST_GAP && tmr_done && prog_active && prog_step == 2'h3) begin
      dens_now <= prog_target;
      dens_known <= 1'b1;
    end
  end

  // track whether the last access outside programming touched the highest address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_was_high <= 1'b0;
    end else if (state == ST_STROBE && tmr_done && !prog_active) begin
      last_was_high <= (cur_addr == `PSC_HIGHEST_ADDR);
    end else if (state == ST_SLEEP && (!dens_known || dens_now == PSC_DENS_NONE)) begin
      last_was_high <= 1'b0;
    end
  end

  // read data capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= `PSC_DATA_W'h0;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= 1'b0;
      if (state == ST_STROBE && tmr_done && cur_op != PSC_OP_WRITE && !prog_active && !dummy_active) begin
        rdata <= mem_dq_in;
        rdata_valid <= 1'b1;
      end
    end
  end

  // pin drive
  logic strobe;
  logic active;
  assign strobe = (state == ST_STROBE);
  assign active = (state == ST_SETUP) || strobe;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_dq_out <= `PSC_DATA_W'h0;
    end else if (state == ST_SETUP || state == ST_DUMMY) begin
      mem_dq_out <= cur_data;
    end
  end

  // address follows the held request so it is settled before write enable falls
  assign mem_addr = (cur_op == PSC_OP_PAGE) ? {cur_addr[`PSC_ADDR_W-1:3], page_idx} : cur_addr;

  always_comb begin
    mem_ctl.low_power_n = !(state == ST_PWR_LOW || state == ST_SLEEP);
    mem_ctl.ram_select_n = !(active || state == ST_DUMMY) || state == ST_PWR_LOW;
    mem_ctl.output_enable_n = !(strobe && cur_op != PSC_OP_WRITE);
    mem_ctl.write_enable_n = !(strobe && cur_op == PSC_OP_WRITE);
    mem_ctl.upper_byte_enable_n = !(active && cur_be[1]);
    mem_ctl.lower_byte_enable_n = !(active && cur_be[0]);
  end

  assign mem_dq_oe = active && cur_op == PSC_OP_WRITE;
  assign req_ready = (state == ST_READY) && !sleep_req && !prog_valid;
  assign init_done = !(state == ST_PWR_LOW || state == ST_PWR_IDLE || state == ST_WAKE);
endmodule : psc_host
`default_nettype wire

// file: hw/psc_pkg.sv
// psc_pkg: types shared by the pseudo-static RAM host controller
// assumes psc_defines.svh is on the include path
`include "psc_defines.svh"
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_DENS_16 = 2'h0,
    PSC_DENS_8 = 2'h1,
    PSC_DENS_4 = 2'h2,
    PSC_DENS_NONE = 2'h3
  } psc_dens_e;

  typedef enum logic [1:0] {
    PSC_OP_READ = 2'h0,
    PSC_OP_WRITE = 2'h1,
    PSC_OP_PAGE = 2'h2
  } psc_op_e;

  typedef struct packed {
    psc_op_e op;
    logic [`PSC_ADDR_W-1:0] addr;
    logic [`PSC_DATA_W-1:0] wdata;
    logic [1:0] byte_en;
  } psc_req_s;

  typedef struct packed {
    logic ram_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic upper_byte_enable_n;
    logic lower_byte_enable_n;
    logic low_power_n;
  } psc_ctl_s;
endpackage : psc_pkg

// file: hw/psc_timer.sv
// psc_timer: down counter that signals when a loaded interval has elapsed
// assumes one clock domain, load wins over counting
`timescale 1ns/1ns
`default_nettype none
`include "psc_defines.svh"
module psc_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [`PSC_CNT_W-1:0] count,
  output logic done
);
  logic [`PSC_CNT_W-1:0] remain;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remain <= `PSC_CNT_W'h0;
    end else if (load) begin
      remain <= count;
    end else if (remain != `PSC_CNT_W'h0) begin
      remain <= remain - `PSC_CNT_W'h1;
    end
  end

  // done looks only at the count so a load that depends on done cannot loop back
  assign done = (remain == `PSC_CNT_W'h0);
endmodule : psc_timer
`default_nettype wire

// file: verif/psc_host_checker.sv
// psc_host_checker: pin and timing checks on the host controller ports
// assumes it is bound into psc_host and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
`include "psc_defines.svh"
module psc_host_checker
  import psc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire logic [`PSC_ADDR_W-1:0] mem_addr,
  input wire psc_ctl_s mem_ctl,
  input wire logic [`PSC_DATA_W-1:0] mem_dq_out,
  input wire logic mem_dq_oe,
  input wire psc_dens_e dens_now,
  input wire logic dens_known
);
  wire sel_n = mem_ctl.ram_select_n;
  wire oe_n = mem_ctl.output_enable_n;
  wire we_n = mem_ctl.write_enable_n;
  wire lp_n = mem_ctl.low_power_n;
  logic [15:0] cnt;
  logic pu;
  logic boot;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cnt: cycles since the low-power pin last moved; pu: a full idle hold is owed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      pu <= 1'b1;
      boot <= 1'b1;
    end else begin
      cnt <= $changed(lp_n) ? '0 : cnt + 16'h1;
      if ($rose(lp_n)) boot <= 1'b0;
      if (!sel_n) pu <= 1'b0;
      else if ($fell(lp_n) && !(dens_known && dens_now != PSC_DENS_NONE)) pu <= 1'b1;
    end
  end
  sequence wr_zero;
    $fell(we_n) && mem_addr == `PSC_HIGHEST_ADDR && mem_dq_out == 16'h0000;
  endsequence
  sequence wr_code;
    $fell(we_n) && mem_addr == `PSC_HIGHEST_ADDR && mem_dq_out inside {[16'h0004:16'h0007]};
  endsequence
  sleep_hold_a: assert property (boot && $rose(lp_n) |-> cnt >= 16'h03e7) else $error("wake too early");
  select_first_a: assert property ($rose(lp_n) |-> sel_n && $past(sel_n)) else $error("select low at wake");
  idle_hold_a: assert property (pu && $fell(sel_n) |-> cnt >= 16'h0f9f) else $error("idle hold short");
  read_pins_a: assert property (!oe_n |-> lp_n && we_n) else $error("read pins wrong");
  write_pins_a: assert property (!we_n |-> lp_n && oe_n) else $error("write pins wrong");
  addr_still_a: assert property (!sel_n && !we_n |-> $stable(mem_addr)) else $error("address moved");
  dq_clash_a: assert property (mem_dq_oe |-> oe_n) else $error("data clash");
  oe_soon_a: assert property ($fell(sel_n) |-> ##[0:199] (!oe_n || !we_n)) else $error("strobe late");
  prog_writes_a: assert property (wr_zero |-> ##[2:12] wr_code) else $error("no code write");
endmodule : psc_host_checker
bind psc_host psc_host_checker psc_host_checker_i (.clk, .rst, .mem_addr, .mem_ctl, .mem_dq_out, .mem_dq_oe,
  .dens_now, .dens_known);
`default_nettype wire

// file: verif/psc_host_tb.sv
// psc_host_tb: self-checking bench for the pseudo-static RAM host controller
// assumes psc_host, psc_mem_model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "psc_defines.svh"
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module psc_host_tb
  import psc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic prog_valid = 1'b0;
  logic sleep_req = 1'b0;
  logic quiet = 1'b0;
  psc_req_s req = '0;
  psc_dens_e prog_dens = PSC_DENS_16;
  logic req_ready, rdata_valid, init_done, dens_known, mem_dq_oe;
  logic [15:0] rdata, mem_dq_in, mem_dq_out, mode, d, ex;
  logic [21:0] mem_addr;
  psc_ctl_s mem_ctl;
  psc_dens_e dens_now;
  logic [15:0] exp_q [$];
  logic [15:0] shadow [0:15];
  logic [1:0] be;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int wt;
  always #25 clk = ~clk;
  psc_host psc_host_i (.clk, .rst, .req_valid, .req, .req_ready, .rdata, .rdata_valid, .prog_valid, .prog_dens,
    .sleep_req, .init_done, .dens_now, .dens_known, .mem_addr, .mem_ctl, .mem_dq_in, .mem_dq_out, .mem_dq_oe);
  psc_mem_model psc_mem_model_i (.clk, .rst, .addr(mem_addr), .ctl(mem_ctl), .dq_host(mem_dq_out),
    .dq_dev(mem_dq_in), .mode);
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic wait_ready(int lim);
    wt = 0;
    while (req_ready !== 1'b1 && wt < lim) begin
      @(negedge clk);
      wt++;
    end
    `CHK("ready", 1'b1, req_ready)
  endtask : wait_ready
  task automatic op(psc_op_e o, logic [21:0] a, logic [15:0] w, logic [1:0] b);
    wait_ready(60);
    req <= '{o, a, w, b};
    req_valid <= 1'b1;
    @(negedge clk);
    req_valid <= 1'b0;
  endtask : op
  // read results are matched in issue order
  always @(posedge clk) begin
    cyc++;
    if (rdata_valid === 1'b1 && !quiet) begin
      ex = exp_q.pop_front();
      `CHK("rdata", ex, rdata)
    end
    if (cyc == 40000) begin
      `CHK("timeout", 0, 1)
      wrap_up();
    end
  end
  initial begin
    void'($urandom(19));
    repeat (3) @(negedge clk);
    rst <= 1'b0;
    `CHK("booting", 1'b0, init_done)
    wait_ready(6000);
    `CHK("init", 1'b1, wt > 4997)
    `CHK("init_done", 1'b1, init_done)
    for (int i = 0; i < 32; i++) begin
      d = 16'($urandom);
      be = i < 16 ? 2'h3 : 2'($urandom);
      if (be[1]) shadow[i % 16][15:8] = d[15:8];
      if (be[0]) shadow[i % 16][7:0] = d[7:0];
      op(PSC_OP_WRITE, 22'(i % 16), d, be);
    end
    for (int i = 0; i < 8; i++) exp_q.push_back(shadow[i]);
    op(PSC_OP_PAGE, 22'h0, 16'h0, 2'h3);
    for (int i = 8; i < 16; i++) begin
      exp_q.push_back(shadow[i]);
      op(PSC_OP_READ, 22'(i), 16'h0, 2'h3);
    end
    wait_ready(60);
    `CHK("pending", 0, exp_q.size())
    quiet = 1'b1;
    op(PSC_OP_READ, `PSC_HIGHEST_ADDR, 16'h0, 2'h3);
    for (int k = 0; k < 4; k++) begin
      wait_ready(60);
      prog_dens <= psc_dens_e'(k);
      prog_valid <= 1'b1;
      @(negedge clk);
      prog_valid <= 1'b0;
      wait_ready(200);
      `CHK("mode", 16'h0004 + 16'(k), mode)
      `CHK("dens", psc_dens_e'(k), dens_now)
      if (k > 1) begin
        sleep_req <= 1'b1;
        repeat (20) @(negedge clk);
        `CHK("sleep", 1'b0, mem_ctl.low_power_n)
        sleep_req <= 1'b0;
        wait_ready(6000);
        `CHK("wake", k == 3, wt > 3997)
      end
    end
    rst <= 1'b1;
    @(negedge clk);
    rst <= 1'b0;
    wait_ready(6000);
    `CHK("known", 1'b0, dens_known)
    wrap_up();
  end
endmodule : psc_host_tb
`default_nettype wire

// file: verif/psc_mem_model.sv
// psc_mem_model: behavioural pseudo-static RAM die with refresh-density register
// assumes pins settle before each host clock edge; 256 words, upper address bits ignored except in the highest-address match
`timescale 1ns/1ns
`default_nettype none
`include "psc_defines.svh"
module psc_mem_model
  import psc_pkg::*;
(
  // clock and power
  input wire logic clk,
  input wire logic rst,
  // memory pins
  input wire logic [`PSC_ADDR_W-1:0] addr,
  input wire psc_ctl_s ctl,
  input wire logic [`PSC_DATA_W-1:0] dq_host,
  output logic [`PSC_DATA_W-1:0] dq_dev,
  output logic [`PSC_DATA_W-1:0] mode
);
  logic [15:0] mem [0:255];
  logic [17:0] hist [0:4] = '{default: '0};
  logic [15:0] wd = 16'h0000;
  logic [15:0] junk = 16'h5a5a;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic hi = 1'b0;
  wire wr = !ctl.ram_select_n && !ctl.write_enable_n;
  // released bus shows a pattern that moves every cycle
  assign dq_dev = (!ctl.ram_select_n && !ctl.output_enable_n) ? mem[addr[7:0]] : junk;
  always @(posedge clk) begin
    junk <= ~junk + 16'h1;
    if (rst) mode <= 'x;
    if (!ctl.low_power_n && mode == 16'h0007) mem <= '{default: 'x};
    if (wr && !ctl.upper_byte_enable_n) mem[addr[7:0]][15:8] <= dq_host[15:8];
    if (wr && !ctl.lower_byte_enable_n) mem[addr[7:0]][7:0] <= dq_host[7:0];
    if (!ctl.ram_select_n) begin
      act <= 1'b1;
      hi <= addr == `PSC_HIGHEST_ADDR;
      if (!ctl.output_enable_n) rd <= 1'b1;
      if (wr) wd <= dq_host;
    end else if (act) begin
      act <= 1'b0;
      rd <= 1'b0;
      hist <= '{{rd, hi, wd}, hist[0], hist[1], hist[2], hist[3]};
      if (!rd && hi && wd inside {[16'h0004:16'h0007]} && hist[0] == {2'b01, 16'h0000}
          && hist[1][17:16] == 2'b11 && hist[2][17:16] == 2'b11 && hist[3][17:16] != 2'b11)
        mode <= wd;
    end
  end
endmodule : psc_mem_model
`default_nettype wire
